// *** rtl/fspc_map.vh ***
// Register offsets, field positions and timing counts of the flash sequencer.
`ifndef FSPC_MAP_VH
`define FSPC_MAP_VH

// ---------------------------------------------------------------------------
// Register offsets (word index on the plain register port).
// ---------------------------------------------------------------------------
`define FSPC_OFS_CONTROL 4'h0
`define FSPC_OFS_KEY 4'h1
`define FSPC_OFS_PAGE 4'h2
`define FSPC_OFS_STATUS 4'h3

// ---------------------------------------------------------------------------
// Control register fields.
// ---------------------------------------------------------------------------
`define FSPC_BIT_TRIGGER 15
`define FSPC_BIT_OP_WRITE_ENABLE 14
`define FSPC_BIT_ERR 13
`define FSPC_BIT_ERASE 6
`define FSPC_CTRL_RESET 16'h0000
`define FSPC_KEY_FIRST 8'h55
`define FSPC_KEY_SECOND 8'hAA

// ---------------------------------------------------------------------------
// Operation codes.
// ---------------------------------------------------------------------------
`define FSPC_OP_BULK 4'hF
`define FSPC_OP_GSEG 4'hD
`define FSPC_OP_SSEG 4'hC
`define FSPC_OP_WORD 4'h3
`define FSPC_OP_PAGE 4'h2
`define FSPC_OP_ROW 4'h1
`define FSPC_OP_CFG 4'h0

// ---------------------------------------------------------------------------
// Geometry and timing.
// ---------------------------------------------------------------------------
`define FSPC_ROW_WORDS 64
`define FSPC_PAGE_WORDS 512
`define FSPC_ROW_TIME_CYC 11064
`define FSPC_OP_TIME_CYC 16

`endif

// *** rtl/fspc_hold_buffer.v ***
// Holding buffer of 64 program words with registered read data.
`timescale 1ns/100ps

module fspc_hold_buffer (
    input wire ref_clk_i,
    input wire wr_en_i,
    input wire [5:0] wr_idx_i,
    input wire [23:0] wr_data_i,
    input wire [23:0] wr_mask_i,
    input wire [5:0] rd_idx_i,
    output reg [23:0] rd_data_o
);

    reg [23:0] mem_q [0:63]; // Holding words.

    // -----------------------------------------------------------------------
    // Masked write and registered read.
    // -----------------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem_q[wr_idx_i] <= (mem_q[wr_idx_i] & ~wr_mask_i) |
                               (wr_data_i & wr_mask_i);
        end
        rd_data_o <= mem_q[rd_idx_i];
    end

endmodule // fspc_hold_buffer

// *** rtl/fspc_osc_tick.v ***
// Divider that turns the system clock into fast oscillator tick pulses.
`timescale 1ns/100ps

module fspc_osc_tick (
    input wire ref_clk_i,
    input wire reset_i,
    input wire [3:0] div_i,
    output reg tick_o
);

    reg [3:0] cnt_q; // Divider count.

    // -----------------------------------------------------------------------
    // One-cycle tick every div_i+1 clocks.
    // -----------------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            cnt_q <= 4'h0;
            tick_o <= 1'b0;
        end else if (cnt_q >= div_i) begin
            cnt_q <= 4'h0;
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            tick_o <= 1'b0;
        end
    end

endmodule // fspc_osc_tick

// *** rtl/fspc_ctrl.v ***
// Self-programming sequencer: registers, key unlock, table access, timing.
`timescale 1ns/100ps
`include "fspc_map.vh"

module fspc_ctrl #(
    parameter ROW_CYC = `FSPC_ROW_TIME_CYC
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire [3:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [15:0] rdata_o,
    input wire [3:0] osc_div_i,
    input wire tbl_wr_i,
    input wire tbl_rd_i,
    input wire tbl_high_i,
    input wire tbl_byte_i,
    input wire [15:0] tbl_ea_i,
    input wire [15:0] tbl_wdata_i,
    output reg [15:0] tbl_rdata_o,
    output reg cpu_stall_o,
    output reg arr_prog_o,
    output reg arr_erase_o,
    output reg [3:0] arr_op_o,
    output reg [23:0] arr_addr_o,
    output reg [23:0] arr_wdata_o,
    input wire [23:0] arr_rdata_i,
    output reg busy_o
);

    // -----------------------------------------------------------------------
    // State encoding.
    // -----------------------------------------------------------------------
    localparam ST_IDLE = 3'b001; // Waiting for a trigger.
    localparam ST_RUN = 3'b010; // Self-timed operation running.
    localparam ST_DONE = 3'b100; // Completion cleanup.

    reg [2:0] state_q; // Sequencer state.
    reg trig_q; // Operation trigger.
    reg op_write_enable_q; // Write enable.
    reg err_q; // Sequence error flag.
    reg erase_q; // Erase select.
    reg [3:0] op_q; // Operation code.
    reg [7:0] page_q; // Table page.
    reg [1:0] key_q; // Key progress: 1 after 55, 2 after AA.
    reg [13:0] tmr_q; // Oscillator cycles left.
    reg [23:0] base_q; // Latched base address.
    reg [5:0] widx_q; // Row word index during commit.
    reg [23:0] tbl_addr; // Combined table address.
    reg [23:0] wmask; // Buffer write mask.
    reg [23:0] wdata; // Buffer write data.
    reg op_valid; // Code is implemented for the class.
    reg [13:0] op_len; // Length in oscillator cycles.
    wire tick; // Oscillator tick.
    wire [23:0] buf_rd; // Buffer read word.
    wire trig_wr; // Software sets the trigger.
    reg arr_seen_q; // Command issued in this run.
    reg commit_done_q; // Buffer commit finished.
    wire commit_go; // A word leaves this cycle.
    wire [5:0] rd_idx; // Buffer word to read.

    // -----------------------------------------------------------------------
    // Leaf instances.
    // -----------------------------------------------------------------------
    fspc_osc_tick u_tick (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .div_i(osc_div_i),
        .tick_o(tick)
    );

    fspc_hold_buffer u_buf (
        .ref_clk_i(ref_clk_i),
        .wr_en_i(tbl_wr_i && (state_q == ST_IDLE)),
        .wr_idx_i(tbl_addr[6:1]),
        .wr_data_i(wdata),
        .wr_mask_i(wmask),
        .rd_idx_i(rd_idx),
        .rd_data_o(buf_rd)
    );

    // -----------------------------------------------------------------------
    // Table address and write lanes.
    // -----------------------------------------------------------------------
    always @* begin
        tbl_addr = {page_q, tbl_ea_i};
        wmask = 24'h000000;
        wdata = 24'h000000;
        if (tbl_high_i) begin
            // High half reaches bits 23:16; odd byte is phantom.
            wdata = {tbl_wdata_i[7:0], 16'h0000};
            if (!tbl_byte_i || !tbl_ea_i[0]) begin
                wmask = 24'hFF0000;
            end
        end else if (tbl_byte_i) begin
            // Byte write to one lane of the low word.
            wdata = {8'h00, tbl_wdata_i[7:0], tbl_wdata_i[7:0]};
            wmask = tbl_ea_i[0] ? 24'h00FF00 : 24'h0000FF;
        end else begin
            wdata = {8'h00, tbl_wdata_i};
            wmask = 24'h00FFFF;
        end
    end

    // -----------------------------------------------------------------------
    // Operation decode for the selected class.
    // -----------------------------------------------------------------------
    always @* begin
        op_valid = 1'b0;
        op_len = 14'd`FSPC_OP_TIME_CYC;
        if (erase_q) begin
            // Erase codes; 0011 and 0001 are no-operations.
            case (op_q)
                `FSPC_OP_BULK: op_valid = 1'b1;
                `FSPC_OP_GSEG: op_valid = 1'b1;
                `FSPC_OP_SSEG: op_valid = 1'b1;
                `FSPC_OP_PAGE: op_valid = 1'b1;
                `FSPC_OP_CFG: op_valid = 1'b1;
                default: op_valid = 1'b0;
            endcase
        end else begin
            // Program codes; 1111, 1101, 1100, 0010 do nothing.
            case (op_q)
                `FSPC_OP_WORD: op_valid = 1'b1;
                `FSPC_OP_ROW: begin
                    op_valid = 1'b1;
                    op_len = ROW_CYC[13:0];
                end
                `FSPC_OP_CFG: op_valid = 1'b1;
                default: op_valid = 1'b0;
            endcase
        end
    end

    assign trig_wr = wr_i && (addr_i == `FSPC_OFS_CONTROL) &&
                     wdata_i[`FSPC_BIT_TRIGGER];

    // Buffer commit path.
    // One word leaves per cycle until done.
    // The buffer read port is registered,
    // so a row copy reads one word ahead.
    // A single word program sends the word
    // at the latched table address.
    assign commit_go = (state_q == ST_RUN) && arr_seen_q && op_valid &&
                       !erase_q && !commit_done_q;
    assign rd_idx = (op_q != `FSPC_OP_ROW) ? base_q[6:1] :
                    (commit_go ? widx_q + 6'd1 : widx_q);

    // -----------------------------------------------------------------------
    // Registers, key unlock and sequencer.
    // reset_i stands for power-on reset only; no other reset reaches here.
    // -----------------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
            trig_q <= 1'b0;
            op_write_enable_q <= 1'b0;
            err_q <= 1'b0;
            erase_q <= 1'b0;
            op_q <= 4'h0;
            page_q <= 8'h00;
            key_q <= 2'd0;
            tmr_q <= 14'd0;
            base_q <= 24'h000000;
            widx_q <= 6'd0;
            // Run helpers start clear.
            arr_seen_q <= 1'b0;
            commit_done_q <= 1'b0;
            cpu_stall_o <= 1'b0;
            arr_prog_o <= 1'b0;
            arr_erase_o <= 1'b0;
            arr_op_o <= 4'h0;
            arr_addr_o <= 24'h000000;
            arr_wdata_o <= 24'h000000;
            busy_o <= 1'b0;
        end else begin
            arr_prog_o <= 1'b0;
            arr_erase_o <= 1'b0;
            // Key progress: any other write breaks the sequence.
            if (wr_i) begin
                if (addr_i == `FSPC_OFS_KEY &&
                    wdata_i[7:0] == `FSPC_KEY_FIRST) begin
                    key_q <= 2'd1;
                end else if (addr_i == `FSPC_OFS_KEY && key_q == 2'd1 &&
                             wdata_i[7:0] == `FSPC_KEY_SECOND) begin
                    key_q <= 2'd2;
                end else begin
                    key_q <= 2'd0;
                end
            end
            // Table page register.
            if (wr_i && addr_i == `FSPC_OFS_PAGE) begin
                page_q <= wdata_i[7:0];
            end
            // Any table write while idle latches the target base address.
            if (tbl_wr_i && state_q == ST_IDLE) begin
                base_q <= tbl_addr;
            end
            case (state_q)
                ST_IDLE: begin
                    if (wr_i && addr_i == `FSPC_OFS_CONTROL) begin
                        op_write_enable_q <= wdata_i[`FSPC_BIT_OP_WRITE_ENABLE];
                        erase_q <= wdata_i[`FSPC_BIT_ERASE];
                        op_q <= wdata_i[3:0];
                        err_q <= wdata_i[`FSPC_BIT_ERR];
                    end
                    if (trig_wr) begin
                        if (key_q != 2'd2 ||
                            !wdata_i[`FSPC_BIT_OP_WRITE_ENABLE]) begin
                            // Refused: array untouched, error set.
                            err_q <= 1'b1;
                            trig_q <= 1'b0;
                        end else begin
                            trig_q <= 1'b1;
                            err_q <= 1'b0;
                            state_q <= ST_RUN;
                            cpu_stall_o <= 1'b1;
                            busy_o <= 1'b1;
                            tmr_q <= 14'd0;
                            widx_q <= 6'd0;
                        end
                    end
                end
                ST_RUN: begin
                    // First cycle loads length, drives the code and issues any erase; program words follow.
                    if (tmr_q == 14'd0 && !arr_seen_q) begin
                        tmr_q <= op_len;
                        arr_op_o <= op_q;
                        arr_seen_q <= 1'b1;
                        if (op_valid && erase_q) begin
                            arr_erase_o <= 1'b1;
                            // Pages align on 512-word boundaries.
                            arr_addr_o <= {base_q[23:10], 10'h000};
                        end
                    end else if (tick) begin
                        // Time runs on oscillator ticks.
                        tmr_q <= tmr_q - 14'd1;
                    end
                    // Commit buffered words for program operations.
                    // Erase and no-operation codes send no buffered words.
                    if (commit_go) begin
                        arr_prog_o <= 1'b1;
                        arr_wdata_o <= buf_rd;
                        arr_addr_o <= (op_q == `FSPC_OP_ROW) ?
                            {base_q[23:7], widx_q, 1'b0} : base_q;
                        widx_q <= widx_q + 6'd1;
                        if (op_q != `FSPC_OP_ROW || widx_q == 6'd63) begin
                            commit_done_q <= 1'b1;
                        end
                    end
                    if (arr_seen_q && tmr_q == 14'd1 && tick) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Each run needs a fresh unlock before the next.
                    trig_q <= 1'b0;
                    cpu_stall_o <= 1'b0;
                    busy_o <= 1'b0;
                    key_q <= 2'd0;
                    arr_seen_q <= 1'b0;
                    commit_done_q <= 1'b0;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // Register read port: data one cycle after the read strobe.
    // -----------------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            if (addr_i == `FSPC_OFS_CONTROL) begin
                // Unimplemented bits read zero.
                rdata_o <= {trig_q, op_write_enable_q, err_q, 6'h00, erase_q,
                            2'b00, op_q};
            end else if (addr_i == `FSPC_OFS_KEY) begin
                rdata_o <= 16'h0000;
            end else if (addr_i == `FSPC_OFS_PAGE) begin
                rdata_o <= {8'h00, page_q};
            end else if (addr_i == `FSPC_OFS_STATUS) begin
                rdata_o <= {15'h0000, busy_o};
            end else begin
                rdata_o <= 16'h0000;
            end
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // -----------------------------------------------------------------------
    // Table read path from the array word.
    // -----------------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            tbl_rdata_o <= 16'h0000;
        end else if (tbl_rd_i) begin
            if (tbl_high_i) begin
                // Phantom byte reads zero.
                tbl_rdata_o <= (tbl_byte_i && tbl_ea_i[0]) ? 16'h0000 :
                               {8'h00, arr_rdata_i[23:16]};
            end else if (tbl_byte_i) begin
                tbl_rdata_o <= {8'h00, tbl_ea_i[0] ? arr_rdata_i[15:8] :
                                arr_rdata_i[7:0]};
            end else begin
                tbl_rdata_o <= arr_rdata_i[15:0];
            end
        end
    end

endmodule // fspc_ctrl

// *** sim/fspc_ctrl_assertions.sv ***
// Concurrent checks on the ports of the flash sequencer.
`timescale 1ns/100ps
`include "fspc_map.vh"

module fspc_ctrl_chk #(
    parameter ROW_CYC = 40
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire [3:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [15:0] rdata_o,
    input wire [3:0] osc_div_i,
    input wire cpu_stall_o,
    input wire arr_prog_o,
    input wire arr_erase_o,
    input wire busy_o
);
    // -----------------------------------------------------------------
    // Helper logic.
    // -----------------------------------------------------------------
    reg [1:0] key_q; // Unlock progress: 0 none, 1 first key, 2 armed.
    reg [15:0] len_q; // Cycles the current operation has been busy.
    reg row_q; // The last trigger asked for a row program.
    wire [3:0] oc = wdata_i[3:0];
    wire ctl_wr = wr_i && addr_i == `FSPC_OFS_CONTROL && wdata_i[15];
    wire ok_op = wdata_i[6] ? (oc == 4'hF || oc == 4'hD || oc == 4'hC
        || oc == 4'h2 || oc == 4'h0) : (oc == 4'h3 || oc == 4'h1
        || oc == 4'h0);

    // Any write other than the next key in order drops the unlock.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            key_q <= 2'h0;
            row_q <= 1'b0;
        end else if (wr_i) begin
            if (addr_i == `FSPC_OFS_KEY && wdata_i[7:0] == 8'h55)
                key_q <= 2'h1;
            else if (addr_i == `FSPC_OFS_KEY && wdata_i[7:0] == 8'hAA
                && key_q == 2'h1)
                key_q <= 2'h2;
            else
                key_q <= 2'h0;
            if (ctl_wr && !busy_o)
                row_q <= !wdata_i[6] && oc == 4'h1;
        end
    end

    // Counts busy cycles, cleared whenever the block is idle.
    always @(posedge ref_clk_i) begin
        if (reset_i || !busy_o)
            len_q <= 16'h0000;
        else
            len_q <= len_q + 16'h0001;
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    // -----------------------------------------------------------------
    // Properties.
    // -----------------------------------------------------------------
    property p_stall; cpu_stall_o == busy_o; endproperty
    a_stall: assert property (p_stall) else $error("stall differs");
    property p_start;
        ctl_wr && wdata_i[14] && key_q == 2'h2 && ok_op && !busy_o
            |=> cpu_stall_o;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_nokey;
        ctl_wr && key_q != 2'h2 && !busy_o |=> !busy_o [*2];
    endproperty
    a_nokey: assert property (p_nokey) else $error("locked");
    property p_nowren;
        ctl_wr && !wdata_i[14] && !busy_o |=> !busy_o [*2];
    endproperty
    a_nowren: assert property (p_nowren) else $error("op_write_enable");
    property p_keyrd;
        rd_i && addr_i == `FSPC_OFS_KEY |=> rdata_o == 16'h0000;
    endproperty
    a_keyrd: assert property (p_keyrd) else $error("key read");
    property p_resv;
        rd_i && addr_i == `FSPC_OFS_CONTROL
            |=> rdata_o[12:7] == 6'h00 && rdata_o[5:4] == 2'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved");
    property p_trig;
        rd_i && addr_i == `FSPC_OFS_CONTROL && !busy_o && !$past(wr_i)
            |=> !rdata_o[15];
    endproperty
    a_trig: assert property (p_trig) else $error("trigger");
    property p_pulse;
        arr_prog_o || arr_erase_o |-> busy_o || $past(busy_o);
    endproperty
    a_pulse: assert property (p_pulse) else $error("idle pulse");
    property p_excl; !(arr_prog_o && arr_erase_o); endproperty
    a_excl: assert property (p_excl) else $error("both kinds");
    property p_rowlen;
        $fell(busy_o) && row_q |-> len_q >= ROW_CYC * (osc_div_i + 1)
            - osc_div_i - 1 && len_q <= (ROW_CYC + 2) * (osc_div_i + 1) + 4;
    endproperty
    a_rowlen: assert property (p_rowlen) else $error("row time");

    c_start: cover property ($rose(busy_o));
    c_refuse: cover property (ctl_wr && key_q != 2'h2);
    c_erase: cover property (arr_erase_o);
    c_prog: cover property (arr_prog_o);
endmodule // fspc_ctrl_chk

bind fspc_ctrl fspc_ctrl_chk #(.ROW_CYC(ROW_CYC)) i_fspc_ctrl_chk (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .osc_div_i(osc_div_i), .cpu_stall_o(cpu_stall_o),
    .arr_prog_o(arr_prog_o), .arr_erase_o(arr_erase_o), .busy_o(busy_o));

// *** sim/fspc_ctrl_tb.sv ***
// Self-checking bench for the flash sequencer.
`timescale 1ns/100ps
`include "fspc_map.vh"

module fspc_ctrl_tb;
    localparam [3:0] CT = `FSPC_OFS_CONTROL;
    localparam [3:0] KY = `FSPC_OFS_KEY;
    localparam [3:0] PG = `FSPC_OFS_PAGE;
    localparam [27:0] OCS = 28'hFDC3201; // Every operation code.
    reg ref_clk_i = 1'b0;
    reg reset_i = 1'b1;
    reg [3:0] addr_i = 4'h0;
    reg [15:0] wdata_i = 16'h0000;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg [3:0] osc_div_i = 4'h1; // A tick every second clock.
    reg tbl_wr_i = 1'b0;
    reg tbl_rd_i = 1'b0;
    reg tbl_high_i = 1'b0;
    reg tbl_byte_i = 1'b0;
    reg [15:0] tbl_ea_i = 16'h0000;
    reg [15:0] tbl_wdata_i = 16'h0000;
    reg [23:0] arr_rdata_i = 24'h000000;
    wire [15:0] rdata_o;
    wire [15:0] tbl_rdata_o;
    wire cpu_stall_o, arr_prog_o, arr_erase_o, busy_o;
    wire [3:0] arr_op_o;
    wire [23:0] arr_addr_o, arr_wdata_o;
    integer fails = 0, n_compared = 0, cyc = 0, i, k = 0;
    reg [31:0] x = 32'h6937; // Random state.
    reg [15:0] rq[$]; // Expected read data, oldest first.
    reg [30:0] aq[$]; // Expected array commands: addr flag, kind, addr.
    reg rd_d = 1'b0, trd_d = 1'b0, seen = 1'b0, er;
    reg [15:0] e;
    reg [30:0] a;
    reg [3:0] c;
    reg [23:0] rv;
    reg [23:0] hb [0:63]; // Expected buffer words.

    fspc_ctrl #(.ROW_CYC(40)) i_fspc_ctrl (.ref_clk_i(ref_clk_i),
        .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .osc_div_i(osc_div_i),
        .tbl_wr_i(tbl_wr_i), .tbl_rd_i(tbl_rd_i), .tbl_high_i(tbl_high_i),
        .tbl_byte_i(tbl_byte_i), .tbl_ea_i(tbl_ea_i),
        .tbl_wdata_i(tbl_wdata_i), .tbl_rdata_o(tbl_rdata_o),
        .cpu_stall_o(cpu_stall_o), .arr_prog_o(arr_prog_o),
        .arr_erase_o(arr_erase_o), .arr_op_o(arr_op_o),
        .arr_addr_o(arr_addr_o), .arr_wdata_o(arr_wdata_o),
        .arr_rdata_i(arr_rdata_i), .busy_o(busy_o));

    always #25 ref_clk_i = !ref_clk_i;

    // -----------------------------------------------------------------
    // Helpers.
    // -----------------------------------------------------------------
    function [31:0] xs(input [31:0] v);
        reg [31:0] t;
        begin
            t = v ^ (v << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction

    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Drives all strobes for one cycle, then waits for the edge.
    task drv(input w, input r, input tw, input tr, input [3:0] ad,
        input [15:0] d);
        begin
            wr_i <= w;
            rd_i <= r;
            tbl_wr_i <= tw;
            tbl_rd_i <= tr;
            addr_i <= ad;
            wdata_i <= d;
            @(posedge ref_clk_i);
        end
    endtask

    task rd(input [3:0] ad, input [15:0] ex);
        begin
            rq.push_back(ex);
            drv(1'b0, 1'b1, 1'b0, 1'b0, ad, 16'h0000);
        end
    endtask

    // One table access followed by a quiet cycle.
    task tbl(input w, input h, input b, input [15:0] ea, input [15:0] d);
        begin
            tbl_high_i <= h;
            tbl_byte_i <= b;
            tbl_ea_i <= ea;
            tbl_wdata_i <= d;
            drv(1'b0, 1'b0, w, !w, addr_i, 16'h0000);
            drv(1'b0, 1'b0, 1'b0, 1'b0, addr_i, 16'h0000);
        end
    endtask

    // Optional unlock, trigger, wait for the end, read control back unless ex is FFFF.
    task op(input [15:0] cw, input [15:0] ex, input key);
        integer n;
        begin
            if (key) begin
                drv(1'b1, 1'b0, 1'b0, 1'b0, KY, 16'h0055);
                drv(1'b1, 1'b0, 1'b0, 1'b0, KY, 16'h00AA);
            end
            drv(1'b1, 1'b0, 1'b0, 1'b0, CT, cw);
            for (n = 0; n < 3 || (busy_o === 1'b1 && n < 2000); n = n + 1)
                drv(1'b0, 1'b0, 1'b0, 1'b0, CT, 16'h0000);
            chk(busy_o, 1'b0);
            if (ex !== 16'hFFFF)
                rd(CT, ex);
            drv(1'b0, 1'b0, 1'b0, 1'b0, CT, 16'h0000);
        end
    endtask

    task complete_run;
        begin
            $display("compared %0d, mismatches %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    // Takes the oldest note whenever a read answer or the first command of a run appears.
    always @(posedge ref_clk_i) begin
        if (rd_d || trd_d) begin
            if (rq.size() == 0)
                chk(32'h1, 32'h0);
            else begin
                e = rq.pop_front();
                chk(rd_d ? rdata_o : tbl_rdata_o, e);
            end
        end
        rd_d <= rd_i;
        trd_d <= tbl_rd_i;
        if ((arr_prog_o || arr_erase_o) && !seen) begin
            seen <= 1'b1;
            if (aq.size() == 0)
                chk(32'h2, 32'h0);
            else begin
                a = aq.pop_front();
                chk({arr_erase_o, arr_prog_o, arr_op_o}, a[29:24]);
                if (a[30])
                    chk(arr_addr_o, a[23:0]);
            end
        end else if (!busy_o && !arr_prog_o && !arr_erase_o) begin
            seen <= 1'b0;
            k = 0;
        end
        if (arr_prog_o) begin
            chk(arr_wdata_o, hb[k]);
            chk(arr_addr_o, 24'h010C00 + 2 * k);
            k = k + 1;
        end
    end

    // Cuts a hang short.
    always @(posedge ref_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            fails = fails + 1;
            complete_run;
        end
    end

    // -----------------------------------------------------------------
    // Main sequence.
    // -----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd(CT, 16'h0000);
        rd(KY, 16'h0000);
        rd(4'hF, 16'h0000);
        drv(1'b1, 1'b0, 1'b0, 1'b0, CT, 16'h5FFF);
        rd(CT, 16'h404F);
        drv(1'b1, 1'b0, 1'b0, 1'b0, KY, 16'h0055);
        rd(KY, 16'h0000);
        drv(1'b1, 1'b0, 1'b0, 1'b0, PG, 16'h0001);
        rd(PG, 16'h0001);
        // Every half, width and byte select against one array word.
        x = xs(x);
        rv = x[23:0];
        arr_rdata_i <= rv;
        for (i = 0; i < 8; i = i + 1) begin
            rq.push_back(i[2] ? ((i[1] && i[0]) ? 16'h0000
                : {8'h00, rv[23:16]}) : (i[1] ? {8'h00, i[0] ? rv[15:8]
                : rv[7:0]} : rv[15:0]));
            tbl(1'b0, i[2], i[1], {15'h0000, i[1] & i[0]}, 16'h0000);
        end
        // Load one aligned row of 64 words, low then high half.
        for (i = 0; i < 64; i = i + 1) begin
            x = xs(x);
            hb[i] = x[23:0];
            tbl(1'b1, 1'b0, 1'b0, 16'h0C00 + 2 * i, x[15:0]);
            tbl(1'b1, 1'b1, 1'b0, 16'h0C00 + 2 * i, {8'h00, x[23:16]});
        end
        tbl(1'b1, 1'b0, 1'b0, 16'h0C00, x[15:0]);
        hb[0][15:0] = x[15:0];
        op(16'hC001, 16'h6001, 1'b0);
        op(16'h8001, 16'h2001, 1'b1);
        drv(1'b1, 1'b0, 1'b0, 1'b0, KY, 16'h0055);
        drv(1'b1, 1'b0, 1'b0, 1'b0, PG, 16'h0001);
        drv(1'b1, 1'b0, 1'b0, 1'b0, KY, 16'h00AA);
        op(16'hC001, 16'h6001, 1'b0);
        // Every code with program and with erase selected.
        for (i = 0; i < 14; i = i + 1) begin
            er = i >= 7;
            c = OCS[4 * (i % 7) +: 4];
            if (er ? (c inside {4'hF, 4'hD, 4'hC, 4'h2, 4'h0})
                : (c inside {4'h3, 4'h1, 4'h0})) begin
                aq.push_back({er && c == 4'h2, er, !er, c, 24'h010C00});
                op({9'h180, er, 2'h0, c}, {9'h080, er, 2'h0, c}, 1'b1);
            end else begin
                op({9'h180, er, 2'h0, c}, 16'hFFFF, 1'b1);
            end
        end
        reset_i <= 1'b1;
        repeat (2) drv(1'b0, 1'b0, 1'b0, 1'b0, CT, 16'h0000);
        reset_i <= 1'b0;
        rd(CT, 16'h0000);
        repeat (3) drv(1'b0, 1'b0, 1'b0, 1'b0, CT, 16'h0000);
        chk(aq.size(), 32'h0);
        complete_run;
    end
endmodule // fspc_ctrl_tb
